// >>> design/mctp_pkg.sv
/*
 * Constants shared by the machine-check, performance-state and thermal
 * register bank: register addresses, field positions, reset values and
 * the cycle counts of the clock modulation divider.
 * Assumes a 40 MHz core clock and a register port with a 12-bit address
 * and 64-bit data.
 */
package mctp_pkg;

   // ==========================================================
   // Register port geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 64;

   // ==========================================================
   // Register addresses
   localparam logic [ADDR_W-1:0] ADDR_MCG_STATUS   = 12'h17A;
   localparam logic [ADDR_W-1:0] ADDR_PERF_STATUS  = 12'h198;
   localparam logic [ADDR_W-1:0] ADDR_PERF_CONTROL = 12'h199;
   localparam logic [ADDR_W-1:0] ADDR_CLOCK_MOD    = 12'h19A;
   localparam logic [ADDR_W-1:0] ADDR_THERM_INT    = 12'h19B;
   localparam logic [ADDR_W-1:0] ADDR_THERM_STATUS = 12'h19C;
   localparam logic [ADDR_W-1:0] ADDR_MODE_CONTROL = 12'h19D;
   localparam logic [ADDR_W-1:0] ADDR_MISC_ENABLE  = 12'h1A0;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS   = 12'h1F0;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE   = 12'h1F1;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR    = 12'h1F2;

   // ==========================================================
   // Field positions
   localparam int MCG_RESTART_IP_VALID_BIT      = 0;
   localparam int MCG_ERROR_IP_VALID_BIT      = 1;
   localparam int MCG_MACHINE_CHECK_IN_PROGRESS_BIT      = 2;
   localparam int PERF_W            = 16;
   localparam int CLKMOD_DUTY_LSB   = 1;
   localparam int DUTY_W            = 3;
   localparam int CLKMOD_EN_BIT     = 4;
   localparam int TINT_HIGH_BIT     = 0;
   localparam int TINT_LOW_BIT      = 1;
   localparam int TSTAT_HOT_BIT     = 0;
   localparam int TSTAT_LOG_BIT     = 1;
   localparam int MODE_SELECT_BIT   = 16;
   localparam int MISC_TCC_EN_BIT   = 3;

   // Interrupt status, enable and clear share this layout.
   localparam int IRQ_W             = 4;
   localparam int IRQ_MC_BIT        = 0;
   localparam int IRQ_SHUTDOWN_BIT  = 1;
   localparam int IRQ_HOT_BIT       = 2;
   localparam int IRQ_COLD_BIT      = 3;

   // ==========================================================
   // Reset values
   localparam logic [PERF_W-1:0] PERF_CONTROL_RST = 16'h0000;
   localparam logic [DUTY_W-1:0] CLKMOD_DUTY_RST  = 3'h0;
   localparam logic [IRQ_W-1:0]  IRQ_ENABLE_RST   = 4'h0;

   // ==========================================================
   // Clock modulation timing
   localparam int CLK_PERIOD_NS      = 25;
   localparam int MOD_STEP_NS        = 200;
   localparam int MOD_STEP_CYCLES    = (MOD_STEP_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
   localparam int DIV_W              = 4;
   localparam logic [DIV_W-1:0] DIV_LAST =
      DIV_W'(MOD_STEP_CYCLES - 1);
   // Duty used by the automatic duty-cycle mode and for duty code zero.
   localparam logic [DUTY_W-1:0] AUTO_DUTY = 3'h4;

endpackage : mctp_pkg

// >>> design/mctp_regs.sv
/*
 * Register bank for machine-check global status, performance-state
 * reporting and targeting, on-demand clock modulation and the automatic
 * thermal monitor, with a sticky interrupt block on top.
 * Assumes all inputs are synchronous to core_clk and that software uses
 * the plain register port: one-cycle strobes, read data one cycle later.
 */
// Function
// - Restart-valid bit 0 reflects resumable pointer
// - Error-IP-valid bit 1 marks pointer tied to error
// - In-progress bit 2 set on machine check
// - Machine check while in progress means shutdown
// - Current performance state in status bits 15:0
// - Control bits 15:0 give target performance state
// - Clock modulation register enables modulation, picks duty
// - Thermal interrupt register enables temperature interrupts
// - Thermal status register shows sensor and log
// - Mode bit 16 picks duty or frequency monitor
// - Control enable clear disables both monitor modes
// - Misc enable bit 3 turns on thermal control
module mctp_regs
   import mctp_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rst,
   // Register port.
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   // Machine-check event source.
   input  wire logic              mc_event,
   input  wire logic              mc_restart_ok,
   input  wire logic              mc_ip_tied_to_error,
   output logic                   mc_exception,
   output logic                   shutdown,
   // Performance state.
   input  wire logic [PERF_W-1:0] perf_state_now,
   output logic      [PERF_W-1:0] perf_state_target,
   // Thermal sensor and the actions it drives.
   input  wire logic              thermal_hot,
   output logic                   core_clk_run,
   output logic                   freq_transition_req,
   output logic                   irq
);

   // ==========================================================
   // State
   typedef struct packed {
      logic                restart_ip_valid;
      logic                error_ip_valid;
      logic                machine_check_in_progress;
      logic                shutdown;
      logic                mc_exception;
      logic [PERF_W-1:0]   perf_target;
      logic                clkmod_en;
      logic [DUTY_W-1:0]   clkmod_duty;
      logic                tint_high_en;
      logic                tint_low_en;
      logic                hot_log;
      logic                hot_prev;
      logic                monitor_mode_select;
      logic                tcc_en;
      logic [IRQ_W-1:0]    irq_enable;
      logic [DIV_W-1:0]    div_cnt;
      logic [DUTY_W-1:0]   phase;
      logic                clk_run;
      logic                freq_req;
      logic [DATA_W-1:0]   rd_data;
   } mctp_state_type;

   mctp_state_type   st_ff;
   mctp_state_type   nxt_st;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;
   logic [IRQ_W-1:0] irq_flags;

   // ==========================================================
   // Combinational next state
   logic              wr_mcg;
   logic              mc_take;
   logic              mc_fatal;
   logic              hot_rise;
   logic              hot_fall;
   logic              duty_mode;
   logic              mod_active;
   logic [DUTY_W-1:0] duty_sel;
   logic              step_en;

   always_comb begin
      nxt_st  = st_ff;
      irq_set = '0;
      irq_clr = '0;
      wr_mcg  = reg_wr && (reg_addr == ADDR_MCG_STATUS);
      // The shutdown state swallows every later event until reset.
      mc_take  = mc_event && !st_ff.shutdown &&
                 !st_ff.machine_check_in_progress;
      mc_fatal = mc_event && !st_ff.shutdown &&
                 st_ff.machine_check_in_progress;
      hot_rise = thermal_hot && !st_ff.hot_prev;
      hot_fall = !thermal_hot && st_ff.hot_prev;

      // Only the three flags are writable; bits 63:3 are dropped.
      if (wr_mcg) begin
         nxt_st.restart_ip_valid          = reg_wdata[MCG_RESTART_IP_VALID_BIT];
         nxt_st.error_ip_valid            = reg_wdata[MCG_ERROR_IP_VALID_BIT];
         nxt_st.machine_check_in_progress =
            reg_wdata[MCG_MACHINE_CHECK_IN_PROGRESS_BIT];
      end
      // A new event outranks a software write in the same cycle.
      nxt_st.mc_exception = mc_take;
      if (mc_take) begin
         nxt_st.restart_ip_valid          = mc_restart_ok;
         nxt_st.error_ip_valid            = mc_ip_tied_to_error;
         nxt_st.machine_check_in_progress = 1'b1;
      end
      if (mc_fatal) begin
         nxt_st.shutdown = 1'b1;
      end

      if (reg_wr && reg_addr == ADDR_PERF_CONTROL) begin
         nxt_st.perf_target = reg_wdata[PERF_W-1:0];
      end else if (reg_wr && reg_addr == ADDR_CLOCK_MOD) begin
         nxt_st.clkmod_en   = reg_wdata[CLKMOD_EN_BIT];
         nxt_st.clkmod_duty =
            reg_wdata[CLKMOD_DUTY_LSB +: DUTY_W];
      end else if (reg_wr && reg_addr == ADDR_THERM_INT) begin
         nxt_st.tint_high_en = reg_wdata[TINT_HIGH_BIT];
         nxt_st.tint_low_en  = reg_wdata[TINT_LOW_BIT];
      end else if (reg_wr && reg_addr == ADDR_THERM_STATUS) begin
         // The log bit can only be cleared by software.
         nxt_st.hot_log = st_ff.hot_log &
                          reg_wdata[TSTAT_LOG_BIT];
      end else if (reg_wr && reg_addr == ADDR_MODE_CONTROL) begin
         nxt_st.monitor_mode_select =
            reg_wdata[MODE_SELECT_BIT];
      end else if (reg_wr && reg_addr == ADDR_MISC_ENABLE) begin
         nxt_st.tcc_en = reg_wdata[MISC_TCC_EN_BIT];
      end else if (reg_wr && reg_addr == ADDR_IRQ_ENABLE) begin
         nxt_st.irq_enable = reg_wdata[IRQ_W-1:0];
      end else if (reg_wr && reg_addr == ADDR_IRQ_CLEAR) begin
         irq_clr = reg_wdata[IRQ_W-1:0];
      end

      // ==========================================================
      // Thermal sensor tracking
      // The sensor level is registered once; both the status bit and
      // the edge detector use that copy, so they can never disagree.
      nxt_st.hot_prev = thermal_hot;
      if (hot_rise) begin
         nxt_st.hot_log = 1'b1;
      end

      // Automatic modes act only while the sensor reports hot and the
      // control circuit is enabled; the select bit alone does nothing.
      duty_mode = st_ff.tcc_en && !st_ff.monitor_mode_select &&
                  st_ff.hot_prev;
      nxt_st.freq_req = st_ff.tcc_en && st_ff.monitor_mode_select &&
                        st_ff.hot_prev;
      mod_active = st_ff.clkmod_en || duty_mode;
      // On-demand duty wins over the automatic one when both are on,
      // so software keeps control of how hard the core is throttled.
      if (st_ff.clkmod_en && st_ff.clkmod_duty != 3'h0) begin
         duty_sel = st_ff.clkmod_duty;
      end else begin
         duty_sel = AUTO_DUTY;
      end

      // ==========================================================
      // Modulation divider
      // The divider runs freely, so a change of duty takes effect at the next
      // cycle's compare, within the running period rather than restarting it.
      step_en = (st_ff.div_cnt == DIV_LAST);
      if (step_en) begin
         nxt_st.div_cnt = '0;
         nxt_st.phase   = st_ff.phase + 3'h1;
      end else begin
         nxt_st.div_cnt = st_ff.div_cnt + 4'h1;
      end
      nxt_st.clk_run = !mod_active || (st_ff.phase < duty_sel);

      // ==========================================================
      // Interrupt events
      // Events are recorded whatever the interrupt enables say, but hot and cold
      // only when their thermal interrupt enable is set; the interrupt enables only
      // gate the output, so software can poll masked events.
      irq_set[IRQ_MC_BIT]       = mc_take;
      irq_set[IRQ_SHUTDOWN_BIT] = mc_fatal;
      irq_set[IRQ_HOT_BIT]      = hot_rise && st_ff.tint_high_en;
      irq_set[IRQ_COLD_BIT]     = hot_fall && st_ff.tint_low_en;

      // ==========================================================
      // Read multiplexer
      // Unmapped addresses and write-only registers read as zero.
      // The data word is cleared when no read is strobed, so a stale
      // value can never be mistaken for a fresh answer.
      nxt_st.rd_data = '0;
      if (reg_rd) begin
         if (reg_addr == ADDR_MCG_STATUS) begin
            nxt_st.rd_data = {61'h0,
                              st_ff.machine_check_in_progress,
                              st_ff.error_ip_valid,
                              st_ff.restart_ip_valid};
         end else if (reg_addr == ADDR_PERF_STATUS) begin
            nxt_st.rd_data = {48'h0,
                              perf_state_now};
         end else if (reg_addr == ADDR_PERF_CONTROL) begin
            nxt_st.rd_data = {48'h0,
                              st_ff.perf_target};
         end else if (reg_addr == ADDR_CLOCK_MOD) begin
            nxt_st.rd_data = {59'h0,
                              st_ff.clkmod_en,
                              st_ff.clkmod_duty,
                              1'b0};
         end else if (reg_addr == ADDR_THERM_INT) begin
            nxt_st.rd_data = {62'h0,
                              st_ff.tint_low_en,
                              st_ff.tint_high_en};
         end else if (reg_addr == ADDR_THERM_STATUS) begin
            nxt_st.rd_data = {62'h0,
                              st_ff.hot_log,
                              st_ff.hot_prev};
         end else if (reg_addr == ADDR_MODE_CONTROL) begin
            nxt_st.rd_data = {47'h0,
                              st_ff.monitor_mode_select,
                              16'h0000};
         end else if (reg_addr == ADDR_MISC_ENABLE) begin
            nxt_st.rd_data = {60'h0,
                              st_ff.tcc_en,
                              3'h0};
         end else if (reg_addr == ADDR_IRQ_STATUS) begin
            nxt_st.rd_data = {60'h0,
                              irq_flags};
         end else if (reg_addr == ADDR_IRQ_ENABLE) begin
            nxt_st.rd_data = {60'h0,
                              st_ff.irq_enable};
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_ff             <= '0;
         st_ff.perf_target <= PERF_CONTROL_RST;
         st_ff.clkmod_duty <= CLKMOD_DUTY_RST;
         st_ff.irq_enable  <= IRQ_ENABLE_RST;
         st_ff.clk_run     <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // Interrupt flags
   mctp_sticky_bits #(
      .WIDTH    (IRQ_W)
   ) u_irq_flags (
      .core_clk (core_clk),
      .rst      (rst),
      .set_bits (irq_set),
      .clr_bits (irq_clr),
      .flags    (irq_flags)
   );

   // ==========================================================
   // Outputs
   assign reg_rdata           = st_ff.rd_data;
   assign mc_exception        = st_ff.mc_exception;
   assign shutdown            = st_ff.shutdown;
   assign perf_state_target   = st_ff.perf_target;
   assign core_clk_run        = st_ff.clk_run;
   assign freq_transition_req = st_ff.freq_req;
   // The interrupt is a level built from flops only, so it carries no
   // glitch from the register port inputs.
   assign irq                 = |(irq_flags & st_ff.irq_enable);

endmodule : mctp_regs

// >>> design/mctp_sticky_bits.sv
/*
 * A row of sticky event flags: each bit is set by its event and cleared
 * by its clear strike, the event winning when both meet in one cycle.
 * Assumes the single core clock and a synchronous active-high reset.
 */
module mctp_sticky_bits
   import mctp_pkg::*;
#(
   parameter int WIDTH = 1
)(
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] set_bits,
   input  wire logic [WIDTH-1:0] clr_bits,
   output logic      [WIDTH-1:0] flags
);

   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } mctp_sticky_state_type;

   mctp_sticky_state_type st_ff;
   mctp_sticky_state_type nxt_st;

   always_comb begin
      nxt_st       = st_ff;
      nxt_st.flags = (st_ff.flags & ~clr_bits) | set_bits;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign flags = st_ff.flags;

endmodule : mctp_sticky_bits

// >>> tb/mctp_regs_assertions.sv
/* Concurrent checks on the register bank, seen from its ports only.
   Assumes the single core clock and the synchronous active-high reset. */
module mctp_regs_checker
   import mctp_pkg::*;
(
   input wire logic              core_clk,
   input wire logic              rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic              mc_event,
   input wire logic              mc_restart_ok,
   input wire logic              mc_ip_tied_to_error,
   input wire logic              mc_exception,
   input wire logic              shutdown,
   input wire logic [PERF_W-1:0] perf_state_now,
   input wire logic [PERF_W-1:0] perf_state_target,
   input wire logic              thermal_hot,
   input wire logic              core_clk_run,
   input wire logic              freq_transition_req,
   input wire logic              irq
);
   // ==========================================================
   // Sequences
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (rst);
   sequence s_mc_taken;
      mc_event && !shutdown;
   endsequence
   sequence s_target_wr;
      reg_wr && reg_addr == ADDR_PERF_CONTROL;
   endsequence

   // ==========================================================
   // Assertions
   chk_perf_status: assert property (reg_rd && reg_addr == ADDR_PERF_STATUS
      |=> reg_rdata == {48'h0, $past(perf_state_now)})
      else $error("performance status read wrong");
   chk_target_write: assert property (s_target_wr
      |=> perf_state_target == PERF_W'($past(reg_wdata)))
      else $error("target not taken from write");
   chk_target_hold: assert property (!(reg_wr && reg_addr == ADDR_PERF_CONTROL)
      |=> $stable(perf_state_target))
      else $error("target changed without write");
   chk_mc_answer: assert property (s_mc_taken
      |=> mc_exception ^ shutdown)
      else $error("machine check event without one answer");
   chk_exc_cause: assert property (mc_exception
      |-> $past(mc_event) && !$past(shutdown))
      else $error("exception without event");
   chk_exc_single: assert property (mc_exception |=> !mc_exception)
      else $error("exception raised twice in a row");
   chk_shut_hold: assert property (shutdown |=> shutdown)
      else $error("shutdown left before reset");
   chk_shut_cause: assert property ($rose(shutdown) |-> $past(mc_event))
      else $error("shutdown without event");
   chk_unmapped_read: assert property (reg_rd && reg_addr == 12'h0FF
      |=> reg_rdata == '0)
      else $error("unmapped read not zero");
   chk_freq_cause: assert property ($rose(freq_transition_req)
      |-> $past(thermal_hot, 2))
      else $error("frequency request without hot sensor");
endmodule : mctp_regs_checker

bind mctp_regs mctp_regs_checker u_chk (.core_clk, .rst, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mc_event, .mc_restart_ok,
   .mc_ip_tied_to_error, .mc_exception, .shutdown, .perf_state_now,
   .perf_state_target, .thermal_hot, .core_clk_run, .freq_transition_req,
   .irq);

// >>> tb/tb.sv
/* Self-checking bench for the register bank: a register model held in
   an associative array is compared with the design at every result.
   Assumes nothing around it: clock, reset and all inputs are made here. */
module tb
   import mctp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              core_clk = 1'b0;
   logic              rst = 1'b1;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic [DATA_W-1:0] reg_rdata;
   logic [PERF_W-1:0] perf_state_now = '0;
   logic [PERF_W-1:0] perf_state_target;
   logic              reg_wr = 1'b0, reg_rd = 1'b0, mc_event = 1'b0;
   logic              mc_restart_ok = 1'b0, mc_ip_tied_to_error = 1'b0;
   logic              thermal_hot = 1'b0;
   logic              mc_exception, shutdown, core_clk_run;
   logic              freq_transition_req, irq;
   logic [DATA_W-1:0] mdl [int];
   logic [ADDR_W-1:0] regs [11] = '{12'h17A, 12'h198, 12'h199, 12'h19A,
      12'h19B, 12'h19C, 12'h19D, 12'h1A0, 12'h1F0, 12'h1F1, 12'h1F2};
   logic [DATA_W-1:0] v64;
   int                err_total = 0;
   int                cmp_count = 0;
   int                n;
   bit                shut;

   always #12.5 core_clk = ~core_clk;

   mctp_regs u_dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .mc_event, .mc_restart_ok, .mc_ip_tied_to_error,
      .mc_exception, .shutdown, .perf_state_now, .perf_state_target,
      .thermal_hot, .core_clk_run, .freq_transition_req, .irq);

   // ==========================================================
   // Tasks
   task automatic chk(string s, logic [63:0] e, logic [63:0] v);
      cmp_count++;
      if (v !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", s, e, v);
      end
   endtask : chk

   task automatic test_done;
      if (err_total == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   // The strobe is dropped and one edge passes, so back-to-back calls
   // never assign the strobe twice in one time step.
   task automatic wr(logic [11:0] a, logic [63:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      case (a)
         12'h17A: mdl[a] = d & 64'h7;
         12'h199: mdl[a] = d & 64'hFFFF;
         12'h19A: mdl[a] = d & 64'h1E;
         12'h19B: mdl[a] = d & 64'h3;
         12'h19C: mdl[a][1] = mdl[a][1] & d[1];
         12'h19D: mdl[a] = d & 64'h10000;
         12'h1A0: mdl[a] = d & 64'h8;
         12'h1F1: mdl[a] = d & 64'hF;
         12'h1F2: mdl[12'h1F0] = mdl[12'h1F0] & ~d;
         default: ;
      endcase
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask : wr

   task automatic rd(logic [11:0] a);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), mdl.exists(a) ? mdl[a] : 64'h0, reg_rdata);
      chk("irq", |(mdl[12'h1F0] & mdl[12'h1F1]), irq);
      @(posedge core_clk);
   endtask : rd

   task automatic mc;
      logic [1:0] v;
      bit         e;
      v = 2'($urandom);
      e = 1'b0;
      mc_event            <= 1'b1;
      mc_restart_ok       <= v[0];
      mc_ip_tied_to_error <= v[1];
      @(posedge core_clk);
      mc_event <= 1'b0;
      #1;
      if (!shut && mdl[12'h17A][2]) begin
         shut = 1'b1;
         mdl[12'h1F0][1] = 1'b1;
      end else if (!shut) begin
         e = 1'b1;
         mdl[12'h17A] = {61'h0, 1'b1, v[1], v[0]};
         mdl[12'h1F0][0] = 1'b1;
      end
      chk("mc_exception", e, mc_exception);
      chk("shutdown", shut, shutdown);
      @(posedge core_clk);
   endtask : mc

   // One modulation period is 64 cycles, so a 64-cycle window counts
   // every phase exactly once whatever its starting point.
   task automatic runs(int e, logic f);
      n = 0;
      repeat (4) @(posedge core_clk);
      repeat (64) begin
         @(posedge core_clk);
         #1;
         if (core_clk_run === 1'b1)
            n++;
      end
      chk("run cycles", e, n);
      chk("freq_req", f, freq_transition_req);
      @(posedge core_clk);
   endtask : runs

   task automatic do_reset;
      rst  <= 1'b1;
      shut = 1'b0;
      foreach (regs[i])
         mdl[regs[i]] = 64'h0;
      repeat (20) @(posedge core_clk);
      // Taken after the edges so the driven status value has settled.
      mdl[12'h198] = {48'h0, perf_state_now};
      rst <= 1'b0;
      @(posedge core_clk);
      #1;
      chk("clk_run", 1'b1, core_clk_run);
      chk("shutdown", 1'b0, shutdown);
      @(posedge core_clk);
      foreach (regs[i])
         rd(regs[i]);
   endtask : do_reset

   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(32'h413BAC57));
      v64 = {$urandom, $urandom};
      perf_state_now <= v64[15:0];
      do_reset();
      repeat (2) begin
         foreach (regs[i]) begin
            wr(regs[i], {$urandom, $urandom});
            rd(regs[i]);
            chk("target", mdl[12'h199][15:0], perf_state_target);
         end
         wr(12'h0FF, '1);
         rd(12'h0FF);
      end
      wr(12'h19A, 64'h0);
      wr(12'h19B, 64'h3);
      wr(12'h1F1, 64'hF);
      wr(12'h19D, 64'h10000);
      wr(12'h1A0, 64'h0);
      thermal_hot <= 1'b1;
      mdl[12'h19C] = 64'h3;
      mdl[12'h1F0][2] = 1'b1;
      runs(64, 1'b0);
      rd(12'h19C);
      wr(12'h1A0, 64'h8);
      runs(64, 1'b1);
      wr(12'h19D, 64'h0);
      runs(32, 1'b0);
      wr(12'h1A0, 64'h0);
      runs(64, 1'b0);
      thermal_hot <= 1'b0;
      mdl[12'h19C][0] = 1'b0;
      mdl[12'h1F0][3] = 1'b1;
      runs(64, 1'b0);
      rd(12'h19C);
      wr(12'h19C, 64'h0);
      rd(12'h19C);
      wr(12'h1F1, 64'h4);
      rd(12'h1F0);
      wr(12'h1F1, 64'h1);
      rd(12'h1F0);
      wr(12'h1F2, 64'hF);
      rd(12'h1F0);
      for (int d = 0; d < 8; d++) begin
         wr(12'h19A, 64'h10 | 64'(d << 1));
         runs(d == 0 ? 32 : d * 8, 1'b0);
      end
      wr(12'h19A, 64'h0);
      wr(12'h17A, 64'h0);
      repeat (4) begin
         mc();
         rd(12'h17A);
         wr(12'h17A, 64'h0);
      end
      repeat (3)
         mc();
      rd(12'h17A);
      wr(12'h1F2, 64'h1);
      rd(12'h1F0);
      do_reset();
      test_done();
   end

   initial begin
      repeat (50000) @(posedge core_clk);
      err_total++;
      test_done();
   end
endmodule : tb
